// ### design/drive_state_identity_status.sv
// drive state word and identity status word composition
`timescale 1ns/1ps
`include "drive_status_cfg.svh"
module drive_state_identity_status (
  input wire logic clock_i, // system clock
  input wire logic resetn_i, // async reset, active low
  input wire logic enable_i, // clock enable
  input wire drive_status_pkg::drive_state_t drive_state_i, // current drive state
  input wire logic quick_stop_off_i, // high unless quick stop active
  input wire logic alarm_i, // alarm present
  input wire logic direction_i, // rotation direction
  input wire logic stop_key_i, // stopped by panel key
  input wire logic ref_exceeded_i, // reference exceeded
  input wire logic ref_reached_i, // reference reached
  input wire logic forced_local_n_i, // forced local, active low
  input wire logic conn_configured_i, // a connection is configured
  input wire logic nv_nondefault_i, // settings differ from defaults
  input wire logic nv_in_use_i, // stored settings in use
  input wire drive_status_pkg::io_mode_t io_mode_i, // i/o connection mode
  input wire logic nv_bad_i, // non-volatile config bad
  input wire logic dup_address_i, // duplicate node address
  input wire logic switch_changed_i, // switch changed since power-up
  input wire logic nv_read_crc_i, // crc error on nv read
  input wire logic drive_fault_i, // drive faulted
  input wire logic link_lost_i, // link to drive lost
  input wire logic nv_write_crc_i, // crc error on nv write
  input wire logic [63:0] drive_serial_i, // full drive serial number
  output logic [15:0] drive_state_word_o, // drive state word
  output logic [15:0] identity_status_word_o, // identity status word
  output logic [31:0] serial_number_o // identity serial attribute
);
  import drive_status_pkg::*;

  logic [6:0] next_code;
  logic minor_rec;
  logic major_rec;
  logic major_unrec;
  logic [3:0] ext_code;
  logic [15:0] next_state_word;
  logic [15:0] next_identity;

  always_comb begin
    case (drive_state_i)
      st_not_ready: next_code = `CODE_NOT_READY;
      st_disabled: next_code = `CODE_DISABLED;
      st_ready: next_code = `CODE_READY;
      st_switched_on: next_code = `CODE_SWITCHED_ON;
      st_op_enabled: next_code = `CODE_OP_ENABLED;
      st_malfunction: next_code = `CODE_MALFUNCTION;
      st_fault_react: next_code = `CODE_FAULT_REACT;
      st_qstop: next_code = `CODE_QSTOP;
      default: next_code = `CODE_NOT_READY;
    endcase
    // quick-stop bit follows input where it is not significant
    case (drive_state_i)
      st_ready, st_switched_on, st_op_enabled: next_code[`QSTOP_BIT] = 1'b1;
      st_qstop: next_code[`QSTOP_BIT] = 1'b0;
      default: next_code[`QSTOP_BIT] = quick_stop_off_i;
    endcase
  end

  assign next_state_word = {direction_i, stop_key_i, 2'b00, ref_exceeded_i, ref_reached_i,
                            forced_local_n_i, 1'b0, alarm_i, next_code[6:5], 1'b0, next_code[3:0]};

  assign minor_rec = dup_address_i | switch_changed_i;
  assign major_rec = nv_read_crc_i | drive_fault_i | link_lost_i;
  assign major_unrec = nv_write_crc_i;

  extended_status ext_sel (
    .io_mode_i(io_mode_i),
    .nv_bad_i(nv_bad_i),
    .major_i(major_rec | major_unrec),
    .code_o(ext_code)
  );

  assign next_identity = {4'h0, major_unrec, major_rec, 1'b0, minor_rec, ext_code,
                          1'b0, nv_nondefault_i & nv_in_use_i, 1'b0, conn_configured_i};

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_state_word_o <= 16'h0000;
    end else if (enable_i) begin
      drive_state_word_o <= next_state_word;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      identity_status_word_o <= 16'h0000;
    end else if (enable_i) begin
      identity_status_word_o <= next_identity;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_number_o <= 32'h0000_0000;
    end else if (enable_i) begin
      serial_number_o <= drive_serial_i[`SERIAL_W-1:0];
    end
  end
endmodule

// ### design/drive_status_cfg.svh
// constants for the drive state and identity status words
// Functional notes
// - state bits: alarm, disabled, quick-stop low, zero
// - not-ready state clears bits 6,3,2,1,0
// - ready, switched-on, op-enabled and quick-stop states have fixed masked code
// - owned bit set when connection configured
// - bits 8,10,11 report three fault severities; bit 9 is zero
// - configured bit: non-default settings in use
// - extended status: unknown, faulted, no connection
// - extended status: bad config, major fault
// - extended status: run or idle connection
// - duplicate address, switch change: minor recoverable
// - read CRC, drive fault, link loss: major recoverable
// - write CRC error: major unrecoverable
// - serial attribute is low four bytes
// - state word tracks current drive state
`ifndef DRIVE_STATUS_CFG_SVH
`define DRIVE_STATUS_CFG_SVH
`define WORD_W 16
`define SERIAL_W 32
`define STATE_MASK 16'h006F
`define QSTOP_BIT 5
`define CODE_NOT_READY 7'h00
`define CODE_DISABLED 7'h40
`define CODE_READY 7'h21
`define CODE_SWITCHED_ON 7'h23
`define CODE_OP_ENABLED 7'h27
`define CODE_MALFUNCTION 7'h08
`define CODE_FAULT_REACT 7'h0F
`define CODE_QSTOP 7'h07
`define EXT_UNKNOWN 4'h0
`define EXT_IO_FAULTED 4'h2
`define EXT_NO_IO 4'h3
`define EXT_NV_BAD 4'h4
`define EXT_MAJOR 4'h5
`define EXT_RUN 4'h6
`define EXT_IDLE 4'h7
`endif

// ### design/drive_status_pkg.sv
// types for the drive status block
package drive_status_pkg;
  typedef enum logic [2:0] {
    st_not_ready,
    st_disabled,
    st_ready,
    st_switched_on,
    st_op_enabled,
    st_malfunction,
    st_fault_react,
    st_qstop
  } drive_state_t;
  typedef enum logic [1:0] {
    io_none,
    io_run,
    io_idle,
    io_faulted
  } io_mode_t;
endpackage

// ### design/extended_status.sv
// extended status code selection for the identity status word
`timescale 1ns/1ps
`include "drive_status_cfg.svh"
module extended_status (
  input wire drive_status_pkg::io_mode_t io_mode_i, // i/o connection mode
  input wire logic nv_bad_i, // non-volatile config bad
  input wire logic major_i, // any major fault
  output logic [3:0] code_o // extended status code
);
  import drive_status_pkg::*;
  // faults take priority over connection mode
  always_comb begin
    if (major_i) begin
      code_o = `EXT_MAJOR;
    end else if (nv_bad_i) begin
      code_o = `EXT_NV_BAD;
    end else begin
      case (io_mode_i)
        io_faulted: code_o = `EXT_IO_FAULTED;
        io_run: code_o = `EXT_RUN;
        io_idle: code_o = `EXT_IDLE;
        io_none: code_o = `EXT_NO_IO;
        default: code_o = `EXT_UNKNOWN;
      endcase
    end
  end
endmodule

// ### tb/dsis_sva.sv
// assertions on the drive status block ports
`timescale 1ns/1ps
module dsis_sva (
  input wire logic clock_i, resetn_i, enable_i, alarm_i, conn_configured_i, nv_nondefault_i, nv_in_use_i,
  input wire logic dup_address_i, switch_changed_i, nv_read_crc_i, drive_fault_i, link_lost_i, nv_write_crc_i,
  input wire logic [63:0] drive_serial_i,
  input wire logic [15:0] drive_state_word_o, identity_status_word_o,
  input wire logic [31:0] serial_number_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  alarm_bit_a: assert property (enable_i |=> drive_state_word_o[7] == $past(alarm_i)) else $error("alarm bit");
  state_zeros_a: assert property (drive_state_word_o[4] == 0 && drive_state_word_o[13:12] == 0 && drive_state_word_o[8] == 0) else $error("state zeros");
  owned_bit_a: assert property (enable_i |=> identity_status_word_o[0] == $past(conn_configured_i)) else $error("owned");
  configured_bit_a: assert property (enable_i |=> identity_status_word_o[2] == $past(nv_nondefault_i && nv_in_use_i)) else $error("cfg");
  minor_fault_a: assert property (enable_i |=> identity_status_word_o[8] == $past(dup_address_i || switch_changed_i)) else $error("minor");
  major_rec_a: assert property (enable_i |=> identity_status_word_o[10] == $past(nv_read_crc_i || drive_fault_i || link_lost_i)) else $error("major");
  major_unrec_a: assert property (enable_i |=> identity_status_word_o[11] == $past(nv_write_crc_i)) else $error("unrec");
  minor_unrec_a: assert property (identity_status_word_o[9] == 0) else $error("minor unrec");
  serial_low_a: assert property (enable_i |=> serial_number_o == $past(drive_serial_i[31:0])) else $error("serial");
  id_reserved_a: assert property (identity_status_word_o[15:12] == 0 && identity_status_word_o[3] == 0 && identity_status_word_o[1] == 0) else $error("reserved");
  frozen_outputs_a: assert property (!enable_i |=> $stable(drive_state_word_o) && $stable(identity_status_word_o)) else $error("hold");
endmodule
bind drive_state_identity_status dsis_sva dsis_sva_i (.*);

// ### tb/fieldbus_master.sv
// master side: masks the state word to identify the drive state
`timescale 1ns/1ps
module fieldbus_master (
  input wire logic [15:0] state_word_i, // state word read
  output logic [15:0] masked_state_value_o // masked state value
);
  assign masked_state_value_o = state_word_i & 16'h006F;
endmodule

// ### tb/test_drive_state_identity_status.sv
// testbench for the drive status block
`timescale 1ns/1ps
module test_drive_state_identity_status;
  logic clk = 0, resetn = 0, en = 1;
  logic [21:0] v = 0, pv;
  logic [63:0] s = 0, ps;
  logic [15:0] dsw, isw, msk;
  logic [31:0] ser;
  int err_count = 0, total_checks = 0;
  always #25 clk = ~clk;
  drive_state_identity_status drive_state_identity_status_i (.clock_i(clk), .resetn_i(resetn), .enable_i(en),
    .drive_state_i(drive_status_pkg::drive_state_t'(v[2:0])), .quick_stop_off_i(v[3]), .alarm_i(v[4]),
    .direction_i(v[5]), .stop_key_i(v[6]), .ref_exceeded_i(v[7]), .ref_reached_i(v[8]), .forced_local_n_i(v[9]),
    .conn_configured_i(v[10]), .nv_nondefault_i(v[11]), .nv_in_use_i(v[12]),
    .io_mode_i(drive_status_pkg::io_mode_t'(v[14:13])), .nv_bad_i(v[15]), .dup_address_i(v[16]),
    .switch_changed_i(v[17]), .nv_read_crc_i(v[18]), .drive_fault_i(v[19]), .link_lost_i(v[20]),
    .nv_write_crc_i(v[21]), .drive_serial_i(s), .drive_state_word_o(dsw), .identity_status_word_o(isw),
    .serial_number_o(ser));
  fieldbus_master fieldbus_master_i (.state_word_i(dsw), .masked_state_value_o(msk));
  function automatic logic [15:0] es(logic [21:0] x);
    logic [6:0] c;
    case (x[2:0])
      0: c = 7'h00; 1: c = 7'h40; 2: c = 7'h21; 3: c = 7'h23;
      4: c = 7'h27; 5: c = 7'h08; 6: c = 7'h0F; default: c = 7'h07;
    endcase
    if (x[2:0] < 2 || x[2:0] == 5 || x[2:0] == 6) c[5] = x[3];
    return {x[5], x[6], 2'h0, x[7], x[8], x[9], 1'b0, x[4], c};
  endfunction
  function automatic logic [15:0] ei(logic [21:0] x);
    logic [3:0] e;
    e = (|x[21:18]) ? 4'h5 : x[15] ? 4'h4 : x[14:13] == 3 ? 4'h2 : x[14:13] == 1 ? 4'h6 : x[14:13] == 2 ? 4'h7 : 4'h3;
    return {4'h0, x[21], |x[20:18], 1'b0, x[16] | x[17], e, 1'b0, x[11] & x[12], 1'b0, x[10]};
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task report_and_stop;
    if (err_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #50000;
    err_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(97314));
    repeat (20) @(negedge clk);
    chk("reset", 0, {dsw, isw});
    resetn = 1;
    for (int i = 0; i < 64; i++) begin
      v = 22'($urandom);
      s = {$urandom, $urandom};
      v[2:0] = i[2:0];
      v[14:13] = i[4:3];
      if (i[0]) v[21:18] = 0;
      if (i[1]) v[15] = 0;
      en = (i % 5 != 4);
      @(negedge clk);
      if (en) begin
        pv = v;
        ps = s;
      end
      chk("state", es(pv), dsw);
      chk("ident", ei(pv), isw);
      chk("serial", ps[31:0], ser);
      chk("masked", es(pv) & 16'h006F, msk);
    end
    resetn = 0;
    @(negedge clk);
    chk("reset2", 0, {dsw, isw, ser});
    report_and_stop;
  end
endmodule
